//--- design/dso_defines.svh
// Offsets, reset values, codes and timing figures of the drive status block.
// Assumes a 25 MHz APB clock; included by bare name.
`ifndef DSO_DEFINES_SVH
`define DSO_DEFINES_SVH
// Register byte offsets
`define DSO_OFS_MODE2   8'h00
`define DSO_OFS_MONSEL  8'h04
`define DSO_OFS_GAIN    8'h08
`define DSO_OFS_OUTFN   8'h0C
`define DSO_OFS_DETLVL  8'h10
`define DSO_OFS_DETWID  8'h14
`define DSO_OFS_OTLVL   8'h18
`define DSO_OFS_OTTIME  8'h1C
`define DSO_OFS_OTMODE  8'h20
`define DSO_OFS_AIFUNC  8'h24
`define DSO_OFS_INFUNC  8'h28
`define DSO_OFS_SRC     8'h2C
`define DSO_OFS_STATUS  8'h30
`define DSO_OFS_MONOUT  8'h34
// Reset values
`define DSO_RST_GAIN    8'h64
`define DSO_RST_OTLVL   8'hA0
`define DSO_RST_OTTIME  8'h01
`define DSO_RST_INFUNC  8'h08
`define DSO_RST_DETWID  16'h0014
// Field positions
`define DSO_MODE2_MON_BIT  3
`define DSO_MONSEL_BIT     1
`define DSO_OT_EN_BIT      0
`define DSO_OT_ALWAYS_BIT  1
`define DSO_OT_COAST_BIT   2
// Function codes and monitor gain divisor
`define DSO_IN_BB_NO    8'h08
`define DSO_IN_BB_NC    8'h09
`define DSO_IN_HOLD     8'h0A
`define DSO_AI_OTLVL    8'h04
`define DSO_GAIN_DIV    100
// Timing
`define DSO_CLK_KHZ     25000
`define DSO_BB_DELAY_MS 20
`define DSO_OT_STEP_MS  100
`endif

//--- design/dso_pkg.sv
// Types of the drive status block.
// Assumes nothing beyond the defines header.
package dso_pkg;
  typedef enum logic [1:0] {BB_IDLE, BB_DELAY, BB_COAST, BB_WAIT_RUN} dso_bb_state_t;

  typedef struct packed {
    logic [2:0]       s1;
    logic [2:0]       s2;
    logic [2:0]       s3;
    logic [2:0]       pin;
    logic [3:0]       mode2;
    logic [3:0]       monsel;
    logic [3:0]       otmode;
    logic [7:0]       gain;
    logic [7:0]       ot_lvl;
    logic [7:0]       ot_time;
    logic [7:0]       aifunc;
    logic [7:0]       infunc;
    logic [2:0][7:0]  fn;
    logic [15:0]      det_lvl;
    logic [15:0]      det_wid;
    logic [1:0]       src_kp;
    dso_bb_state_t    bb;
    logic [23:0]      bb_cnt;
    logic [23:0]      tick_cnt;
    logic             blink_ph;
    logic [23:0]      ot_sub;
    logic [7:0]       ot_cnt;
    logic             ot_flag;
    logic             ot_coast;
    logic             hold_ramp;
    logic [15:0]      hold_freq;
    logic             coast;
    logic             coast_out;
    logic             fzero;
    logic             permit;
    logic             ss;
    logic             blink;
    logic [2:0]       outs;
    logic [15:0]      mon;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } dso_state_t;
endpackage

//--- design/dso_top.sv
// Drive status and output logic: base block, hold, monitor, outputs, overtorque.
// Assumes an APB master on pclk and drive-core signals on the same clock.
//
// Notes on behaviour
// - Run active and base block: coast after 20 ms, keep command; release starts speed search.
// - No run and base block: after 20 ms coast and force frequency command to zero.
// - Base block released without run: stay stopped until a run command returns.
// - Blocked indicator blinks while base block input is asserted.
// - Code 09 is base block with open contact meaning asserted.
// - Hold freezes ramps and output frequency at value taken on hold.
// - Hold released while running: ramping toward set frequency resumes.
// - Stop during hold cancels hold and runs normal stop.
// - Monitor source from two digits: frequency, current, voltage reference, power.
// - Monitor gain 0.01 to 2.55 in 0.01 steps, default 1.00.
// - Codes 00 running, 01 zero speed, 02 output within width of reference.
// - Code 03: at set frequency and within width of detection level.
// - Code 04 at or below detection level, 05 at or above it.
// - Codes 06 ready, 07 undervoltage, 08 base block coasting.
// - Codes 09, 0A close when frequency or run source is keypad.
// - 0b overtorque, 0C reference missing, 0d brake fault, 0E fault other than processor faults; 0F unused.
// - Overtorque when current at or above level; fault code shown.
// - Overtorque level in percent of rated current, default 160.
// - Condition must persist programmed time, default 0.1 s, before reaction.
// - Mode bit 0 enables detection; bit 2 selects continue or coast.
// - Mode bit 1 clear: only at set frequency; set: except stopping, braking.
// - Analog function 04 takes overtorque level from analog input.
//
// Added by the designer: the register addresses and the APB slave port.
`include "dso_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dso_top #(
  parameter int BB_DELAY_CYC = `DSO_BB_DELAY_MS * `DSO_CLK_KHZ,
  parameter int OT_STEP_CYC  = `DSO_OT_STEP_MS * `DSO_CLK_KHZ
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Contact pins
  input  wire logic        run_fwd_pin,
  input  wire logic        run_rev_pin,
  input  wire logic        mf_input_pin,
  // Drive core
  input  wire logic        drive_running,
  input  wire logic        drive_ready,
  input  wire logic        undervoltage,
  input  wire logic        ref_missing,
  input  wire logic        brake_fault,
  input  wire logic        any_fault,
  input  wire logic        processor_fault_a,
  input  wire logic        processor_fault_b,
  input  wire logic        stopping,
  input  wire logic        dc_braking,
  input  wire logic [15:0] output_freq,
  input  wire logic [15:0] freq_ref,
  input  wire logic [15:0] output_current,
  input  wire logic [15:0] output_vref,
  input  wire logic [15:0] output_power,
  input  wire logic [7:0]  current_pct,
  input  wire logic [7:0]  analog_ot_level,
  // Drive controls
  output logic             coast_stop,
  output logic             freq_cmd_zero,
  output logic             run_permit,
  output logic             speed_search,
  output logic             hold_ramp,
  output logic [15:0]      hold_freq,
  output logic             blocked_blink,
  output logic             overtorque_fault_code,
  output logic [15:0]      monitor_out,
  // Contact outputs
  output logic             relay_out,
  output logic             collector_out_two,
  output logic             collector_out_three
);

  ////////////////////////////////////////////////////////////////////////////
  // State and decode
  dso_pkg::dso_state_t st_reg;
  dso_pkg::dso_state_t st_next;

  logic        run_now;
  logic        bb_act;
  logic        hold_act;
  logic        at_set;
  logic        ot_cond;
  logic [7:0]  ot_level_eff;
  logic [15:0] cond_vec;
  logic [2:0]  fn_hit;
  logic [15:0] mon_src;
  logic [23:0] mon_prod;
  logic [23:0] mon_scaled;
  logic        acc_phase;
  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  assign run_now  = st_reg.pin[0] | st_reg.pin[1];
  assign bb_act   = ((st_reg.infunc == `DSO_IN_BB_NO) & st_reg.pin[2]) |
                    ((st_reg.infunc == `DSO_IN_BB_NC) & ~st_reg.pin[2]);
  assign hold_act = (st_reg.infunc == `DSO_IN_HOLD) & st_reg.pin[2];
  assign at_set   = absdiff(output_freq, freq_ref) <= st_reg.det_wid;
  assign ot_level_eff = (st_reg.aifunc == `DSO_AI_OTLVL) ? analog_ot_level : st_reg.ot_lvl;
  assign ot_cond  = st_reg.otmode[`DSO_OT_EN_BIT] & (current_pct >= ot_level_eff) &
                    (st_reg.otmode[`DSO_OT_ALWAYS_BIT] ? ~(stopping | dc_braking) : at_set);

  ////////////////////////////////////////////////////////////////////////////
  // Output function conditions
  assign cond_vec = {
    1'b0,
    any_fault & ~processor_fault_a & ~processor_fault_b,
    brake_fault,
    ref_missing,
    st_reg.ot_flag,
    st_reg.src_kp[1],
    st_reg.src_kp[0],
    st_reg.coast,
    undervoltage,
    drive_ready,
    output_freq >= st_reg.det_lvl,
    output_freq <= st_reg.det_lvl,
    at_set & (absdiff(output_freq, st_reg.det_lvl) <= st_reg.det_wid),
    at_set,
    output_freq == 16'h0000,
    drive_running
  };

  for (genvar i = 0; i < 3; i++) begin : g_out
    assign fn_hit[i] = (st_reg.fn[i][7:4] == 4'h0) & cond_vec[st_reg.fn[i][3:0]];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Monitor scaling
  always_comb begin
    case ({st_reg.mode2[`DSO_MODE2_MON_BIT], st_reg.monsel[`DSO_MONSEL_BIT]})
      2'b00:   mon_src = output_freq;
      2'b10:   mon_src = output_current;
      2'b01:   mon_src = output_vref;
      default: mon_src = output_power;
    endcase
  end

  assign mon_prod   = mon_src * st_reg.gain;
  assign mon_scaled = mon_prod / 24'(`DSO_GAIN_DIV);

  assign acc_phase = psel & penable & ~st_reg.pready;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.ss = 1'b0;
    // Pin filter: change taken once second and third stages agree
    st_next.s1 = {mf_input_pin, run_rev_pin, run_fwd_pin};
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int k = 0; k < 3; k++) begin
      if (st_reg.s2[k] == st_reg.s3[k]) begin
        st_next.pin[k] = st_reg.s3[k];
      end
    end
    // Free tick for blink
    if (st_reg.tick_cnt == 24'(OT_STEP_CYC - 1)) begin
      st_next.tick_cnt = 24'h000000;
      st_next.blink_ph = ~st_reg.blink_ph;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 24'h000001;
    end
    st_next.blink = bb_act & st_reg.blink_ph;
    // Base block sequence
    case (st_reg.bb)
      dso_pkg::BB_IDLE: begin
        st_next.coast  = 1'b0;
        st_next.fzero  = 1'b0;
        st_next.permit = 1'b1;
        st_next.bb_cnt = 24'h000000;
        if (bb_act) begin
          st_next.bb = dso_pkg::BB_DELAY;
        end
      end
      dso_pkg::BB_DELAY: begin
        if (!bb_act) begin
          st_next.bb = dso_pkg::BB_IDLE;
        end else if (st_reg.bb_cnt == 24'(BB_DELAY_CYC - 1)) begin
          st_next.bb    = dso_pkg::BB_COAST;
          st_next.coast = 1'b1;
          st_next.fzero = ~run_now;
        end else begin
          st_next.bb_cnt = st_reg.bb_cnt + 24'h000001;
        end
      end
      dso_pkg::BB_COAST: begin
        st_next.fzero = ~run_now;
        if (!bb_act) begin
          if (run_now) begin
            st_next.bb    = dso_pkg::BB_IDLE;
            st_next.ss    = 1'b1;
            st_next.coast = 1'b0;
            st_next.fzero = 1'b0;
          end else begin
            st_next.bb     = dso_pkg::BB_WAIT_RUN;
            st_next.coast  = 1'b0;
            st_next.permit = 1'b0;
          end
        end
      end
      dso_pkg::BB_WAIT_RUN: begin
        if (bb_act) begin
          st_next.bb     = dso_pkg::BB_DELAY;
          st_next.bb_cnt = 24'h000000;
        end else if (run_now) begin
          st_next.bb     = dso_pkg::BB_IDLE;
          st_next.permit = 1'b1;
          st_next.fzero  = 1'b0;
        end
      end
      default: st_next.bb = dso_pkg::BB_IDLE;
    endcase
    // Hold
    st_next.hold_ramp = hold_act & run_now & ~stopping;
    if (!st_reg.hold_ramp) begin
      st_next.hold_freq = output_freq;
    end
    // Overtorque persistence
    if (!ot_cond) begin
      st_next.ot_sub  = 24'h000000;
      st_next.ot_cnt  = 8'h00;
      st_next.ot_flag = 1'b0;
    end else if (st_reg.ot_cnt >= st_reg.ot_time) begin
      st_next.ot_flag = 1'b1;
      if (st_reg.otmode[`DSO_OT_COAST_BIT]) begin
        st_next.ot_coast = 1'b1;
      end
    end else if (st_reg.ot_sub == 24'(OT_STEP_CYC - 1)) begin
      st_next.ot_sub = 24'h000000;
      st_next.ot_cnt = st_reg.ot_cnt + 8'h01;
    end else begin
      st_next.ot_sub = st_reg.ot_sub + 24'h000001;
    end
    if (!run_now) begin
      st_next.ot_coast = 1'b0;
    end
    st_next.coast_out = st_next.coast | st_next.ot_coast;
    st_next.outs = fn_hit;
    st_next.mon  = (mon_scaled > 24'h00FFFF) ? 16'hFFFF : mon_scaled[15:0];
    // APB: one wait state, read data registered
    st_next.pready  = acc_phase;
    st_next.pslverr = 1'b0;
    if (acc_phase) begin
      st_next.prdata = 32'h00000000;
      case (paddr)
        `DSO_OFS_MODE2:  st_next.prdata = {28'h0000000, st_reg.mode2};
        `DSO_OFS_MONSEL: st_next.prdata = {28'h0000000, st_reg.monsel};
        `DSO_OFS_GAIN:   st_next.prdata = {24'h000000, st_reg.gain};
        `DSO_OFS_OUTFN:  st_next.prdata = {8'h00, st_reg.fn};
        `DSO_OFS_DETLVL: st_next.prdata = {16'h0000, st_reg.det_lvl};
        `DSO_OFS_DETWID: st_next.prdata = {16'h0000, st_reg.det_wid};
        `DSO_OFS_OTLVL:  st_next.prdata = {24'h000000, st_reg.ot_lvl};
        `DSO_OFS_OTTIME: st_next.prdata = {24'h000000, st_reg.ot_time};
        `DSO_OFS_OTMODE: st_next.prdata = {28'h0000000, st_reg.otmode};
        `DSO_OFS_AIFUNC: st_next.prdata = {24'h000000, st_reg.aifunc};
        `DSO_OFS_INFUNC: st_next.prdata = {24'h000000, st_reg.infunc};
        `DSO_OFS_SRC:    st_next.prdata = {30'h00000000, st_reg.src_kp};
        `DSO_OFS_STATUS: st_next.prdata = {22'h000000, st_reg.pin, st_reg.ot_coast, st_reg.ot_flag,
                                           st_reg.hold_ramp, st_reg.permit, st_reg.fzero,
                                           st_reg.coast, bb_act};
        `DSO_OFS_MONOUT: st_next.prdata = {16'h0000, st_reg.mon};
        default:         st_next.pslverr = 1'b1;
      endcase
    end
    if (psel & penable & st_reg.pready & pwrite) begin
      case (paddr)
        `DSO_OFS_MODE2:  st_next.mode2   = pwdata[3:0];
        `DSO_OFS_MONSEL: st_next.monsel  = pwdata[3:0];
        `DSO_OFS_GAIN:   st_next.gain    = (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
        `DSO_OFS_OUTFN:  st_next.fn      = pwdata[23:0];
        `DSO_OFS_DETLVL: st_next.det_lvl = pwdata[15:0];
        `DSO_OFS_DETWID: st_next.det_wid = pwdata[15:0];
        `DSO_OFS_OTLVL:  st_next.ot_lvl  = pwdata[7:0];
        `DSO_OFS_OTTIME: st_next.ot_time = pwdata[7:0];
        `DSO_OFS_OTMODE: st_next.otmode  = pwdata[3:0];
        `DSO_OFS_AIFUNC: st_next.aifunc  = pwdata[7:0];
        `DSO_OFS_INFUNC: st_next.infunc  = pwdata[7:0];
        `DSO_OFS_SRC:    st_next.src_kp  = pwdata[1:0];
        default:         st_next.src_kp  = st_reg.src_kp;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg         <= '0;
      st_reg.gain    <= `DSO_RST_GAIN;
      st_reg.ot_lvl  <= `DSO_RST_OTLVL;
      st_reg.ot_time <= `DSO_RST_OTTIME;
      st_reg.infunc  <= `DSO_RST_INFUNC;
      st_reg.det_wid <= `DSO_RST_DETWID;
      st_reg.permit  <= 1'b1;
      st_reg.bb      <= dso_pkg::BB_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pready                = st_reg.pready;
  assign pslverr               = st_reg.pslverr;
  assign prdata                = st_reg.prdata;
  assign coast_stop            = st_reg.coast_out;
  assign freq_cmd_zero         = st_reg.fzero;
  assign run_permit            = st_reg.permit;
  assign speed_search          = st_reg.ss;
  assign hold_ramp             = st_reg.hold_ramp;
  assign hold_freq             = st_reg.hold_freq;
  assign blocked_blink         = st_reg.blink;
  assign overtorque_fault_code = st_reg.ot_flag;
  assign monitor_out           = st_reg.mon;
  assign relay_out             = st_reg.outs[0];
  assign collector_out_two     = st_reg.outs[1];
  assign collector_out_three   = st_reg.outs[2];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_bb_coast;
    @(posedge pclk) disable iff (!presetn)
    (st_reg.bb == dso_pkg::BB_DELAY && bb_act && st_reg.bb_cnt == 24'(BB_DELAY_CYC - 1)) |=> coast_stop;
  endproperty
  a_bb_coast: assert property (p_bb_coast) else $error("no coast after base block delay");

  property p_bb_zero;
    @(posedge pclk) disable iff (!presetn)
    (st_reg.bb == dso_pkg::BB_COAST && bb_act && !run_now) |=> freq_cmd_zero;
  endproperty
  a_bb_zero: assert property (p_bb_zero) else $error("command not zeroed without run");

  property p_wait_run;
    @(posedge pclk) disable iff (!presetn)
    (st_reg.bb == dso_pkg::BB_WAIT_RUN && !run_now && !bb_act) |=> !run_permit;
  endproperty
  a_wait_run: assert property (p_wait_run) else $error("restart without run command");

  property p_blink;
    @(posedge pclk) disable iff (!presetn)
    !bb_act |=> !blocked_blink;
  endproperty
  a_blink: assert property (p_blink) else $error("blink without base block");

  property p_nc_contact;
    @(posedge pclk) disable iff (!presetn)
    (st_reg.infunc == `DSO_IN_BB_NC && !st_reg.pin[2] && st_reg.bb == dso_pkg::BB_IDLE)
      |=> st_reg.bb == dso_pkg::BB_DELAY;
  endproperty
  a_nc_contact: assert property (p_nc_contact) else $error("open contact not taken as block");

  property p_hold_freeze;
    @(posedge pclk) disable iff (!presetn)
    hold_ramp ##1 hold_ramp |-> $stable(hold_freq);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("held frequency moved");

  property p_hold_stop;
    @(posedge pclk) disable iff (!presetn)
    (hold_act && !run_now) |=> !hold_ramp;
  endproperty
  a_hold_stop: assert property (p_hold_stop) else $error("hold kept after stop");

  property p_gain;
    @(posedge pclk) disable iff (!presetn)
    st_reg.gain != 8'h00;
  endproperty
  a_gain: assert property (p_gain) else $error("monitor gain zero");

  property p_freq_low;
    @(posedge pclk) disable iff (!presetn)
    (st_reg.fn[0] == 8'h04 && output_freq <= st_reg.det_lvl) |=> relay_out;
  endproperty
  a_freq_low: assert property (p_freq_low) else $error("low detection missed");

  property p_ot_drop;
    @(posedge pclk) disable iff (!presetn)
    !ot_cond |=> !overtorque_fault_code;
  endproperty
  a_ot_drop: assert property (p_ot_drop) else $error("overtorque kept after drop");

  property p_ot_disable;
    @(posedge pclk) disable iff (!presetn)
    !st_reg.otmode[`DSO_OT_EN_BIT] |=> !overtorque_fault_code;
  endproperty
  a_ot_disable: assert property (p_ot_disable) else $error("overtorque while disabled");

endmodule

`default_nettype wire

//--- test/dso_contacts.sv
// Far-side contact model: two run switches and one auxiliary contact.
// Assumes a closed contact reads high at the drive pin.
`timescale 1ns/1ps
`default_nettype none
module dso_contacts (
  // Contact states from the bench
  input  wire logic fwd_closed,
  input  wire logic rev_closed,
  input  wire logic aux_closed,
  // Pins toward the drive
  output logic      run_fwd_pin,
  output logic      run_rev_pin,
  output logic      mf_input_pin
);
  assign run_fwd_pin  = fwd_closed;
  assign run_rev_pin  = rev_closed;
  assign mf_input_pin = aux_closed;
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the drive status block.
// Assumes short delay parameters and an APB master on pclk.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, current_pct, analog_ot_level;
  logic [31:0] pwdata, prdata, rd;
  logic        fwd, rev, blk, run_fwd_pin, run_rev_pin, mf_input_pin;
  logic        drive_running, drive_ready, undervoltage, ref_missing, brake_fault, any_fault;
  logic        processor_fault_a, processor_fault_b, stopping, dc_braking;
  logic [15:0] output_freq, freq_ref, output_current, output_vref, output_power, hold_freq, monitor_out;
  logic        coast_stop, freq_cmd_zero, run_permit, speed_search, hold_ramp, blocked_blink;
  logic        overtorque_fault_code, relay_out, collector_out_two, collector_out_three;
  int          err_count, n_checks, n;
  dso_top #(.BB_DELAY_CYC(20), .OT_STEP_CYC(10)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .prdata, .run_fwd_pin, .run_rev_pin, .mf_input_pin, .drive_running,
    .drive_ready, .undervoltage, .ref_missing, .brake_fault, .any_fault, .processor_fault_a,
    .processor_fault_b, .stopping, .dc_braking, .output_freq, .freq_ref, .output_current, .output_vref,
    .output_power, .current_pct, .analog_ot_level, .coast_stop, .freq_cmd_zero, .run_permit, .speed_search,
    .hold_ramp, .hold_freq, .blocked_blink, .overtorque_fault_code, .monitor_out, .relay_out,
    .collector_out_two, .collector_out_three);
  dso_contacts u_contacts (.fwd_closed(fwd), .rev_closed(rev), .aux_closed(blk), .run_fwd_pin,
    .run_rev_pin, .mf_input_pin);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic tmo(input int lim);
    if (n >= lim) begin
      err_count++;
      test_done;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      err_count++;
      test_done;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic s_regs;
    logic [7:0]  a [4] = '{8'h08, 8'h18, 8'h1C, 8'h28};
    logic [31:0] e [4] = '{32'h64, 32'hA0, 32'h01, 32'h08};
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, a[i], 32'h0);
      chk(rd, e[i], "reset value");
    end
    apb(1'b0, 8'h3C, 32'h0);
    chk(32'(er), 32'h1, "unmapped");
  endtask
  task automatic s_bb_run;
    apb(1'b1, 8'h0C, 32'h08);
    fwd <= 1'b1;
    blk <= 1'b1;
    for (n = 0; n < 40 && coast_stop !== 1'b1; n++) @(posedge pclk);
    tmo(40);
    chk(32'(n >= 20), 32'h1, "coast delay");
    chk(32'(coast_stop), 32'h1, "coast");
    chk(32'(freq_cmd_zero), 32'h0, "cmd kept");
    @(posedge pclk);
    chk(32'(relay_out), 32'h1, "coasting out");
    for (n = 0; n < 30 && blocked_blink !== 1'b1; n++) @(posedge pclk);
    tmo(30);
    chk(32'(blocked_blink), 32'h1, "blink");
    blk <= 1'b0;
    for (n = 0; n < 20 && speed_search !== 1'b1; n++) @(posedge pclk);
    tmo(20);
    chk(32'(speed_search), 32'h1, "search");
    chk(32'(coast_stop), 32'h0, "recover");
    fwd <= 1'b0;
  endtask
  task automatic s_bb_stop;
    apb(1'b1, 8'h28, 32'h09);
    for (n = 0; n < 40 && freq_cmd_zero !== 1'b1; n++) @(posedge pclk);
    tmo(40);
    chk(32'(n >= 18), 32'h1, "zero delay");
    chk(32'(coast_stop), 32'h1, "coast nc");
    blk <= 1'b1;
    for (n = 0; n < 20 && coast_stop !== 1'b0; n++) @(posedge pclk);
    tmo(20);
    chk(32'(run_permit), 32'h0, "stay stopped");
    rev <= 1'b1;
    for (n = 0; n < 20 && run_permit !== 1'b1; n++) @(posedge pclk);
    tmo(20);
    chk(32'(run_permit), 32'h1, "run again");
    rev <= 1'b0;
  endtask
  task automatic s_hold;
    apb(1'b1, 8'h28, 32'h0A);
    fwd           <= 1'b1;
    drive_running <= 1'b1;
    output_freq   <= 16'h1234;
    for (int r = 0; r < 2; r++) begin
      blk <= 1'b1;
      for (n = 0; n < 20 && hold_ramp !== 1'b1; n++) @(posedge pclk);
      tmo(20);
      output_freq <= 16'h2000;
      repeat (3) @(posedge pclk);
      chk({15'h0, hold_ramp, hold_freq}, 32'h11234, "hold");
      output_freq <= 16'h1234;
      if (r == 0) blk <= 1'b0;
      else stopping <= 1'b1;
      for (n = 0; n < 20 && hold_ramp !== 1'b0; n++) @(posedge pclk);
      tmo(20);
      chk(32'(hold_ramp), 32'h0, "hold end");
    end
    stopping <= 1'b0;
    blk      <= 1'b0;
  endtask
  task automatic s_outs;
    logic [15:0] e = 16'h527D;
    output_freq <= 16'h0064;
    freq_ref    <= 16'h006E;
    drive_ready <= 1'b1;
    ref_missing <= 1'b1;
    any_fault   <= 1'b1;
    apb(1'b1, 8'h10, 32'h64);
    apb(1'b1, 8'h2C, 32'h1);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, 8'h0C, {8'h0, c[7:0], c[7:0], c[7:0]});
      repeat (3) @(posedge pclk);
      chk({relay_out, collector_out_two, collector_out_three}, {3{e[c]}}, "out fn");
    end
    processor_fault_a <= 1'b1;
    apb(1'b1, 8'h0C, 32'h0E);
    repeat (3) @(posedge pclk);
    chk(32'(relay_out), 32'h0, "cpu fault");
    processor_fault_a <= 1'b0;
  endtask
  task automatic s_mon;
    logic [15:0] e [4] = '{16'h0032, 16'h0064, 16'h0096, 16'h00C8};
    output_current <= 16'h00C8;
    output_vref    <= 16'h012C;
    output_power   <= 16'h0190;
    apb(1'b1, 8'h08, 32'h32);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h00, {28'h0, i[0], 3'h0});
      apb(1'b1, 8'h04, {30'h0, i[1], 1'b0});
      repeat (3) @(posedge pclk);
      chk(32'(monitor_out), 32'(e[i]), "monitor");
    end
  endtask
  task automatic s_ot;
    current_pct     <= 8'h78;
    analog_ot_level <= 8'hC8;
    apb(1'b1, 8'h18, 32'h64);
    apb(1'b1, 8'h20, 32'h3);
    for (n = 0; n < 40 && overtorque_fault_code !== 1'b1; n++) @(posedge pclk);
    tmo(40);
    chk(32'(n >= 8), 32'h1, "persist");
    chk(32'(overtorque_fault_code), 32'h1, "ot");
    current_pct <= 8'h64;
    repeat (4) @(posedge pclk);
    chk(32'(overtorque_fault_code), 32'h1, "ot equal");
    apb(1'b1, 8'h24, 32'h04);
    for (n = 0; n < 20 && overtorque_fault_code !== 1'b0; n++) @(posedge pclk);
    tmo(20);
    chk(32'(overtorque_fault_code), 32'h0, "analog lvl");
    freq_ref <= 16'h0200;
    apb(1'b1, 8'h24, 32'h0);
    apb(1'b1, 8'h20, 32'h1);
    repeat (30) @(posedge pclk);
    chk(32'(overtorque_fault_code), 32'h0, "set freq only");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, fwd, rev, blk, drive_running, drive_ready} = '0;
    {undervoltage, ref_missing, brake_fault, any_fault, processor_fault_a, processor_fault_b} = '0;
    {stopping, dc_braking, paddr, pwdata, output_freq, freq_ref, output_current} = '0;
    {output_vref, output_power, current_pct, analog_ot_level} = '0;
    err_count = 0;
    n_checks  = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    s_regs;
    s_bb_run;
    s_bb_stop;
    s_hold;
    s_outs;
    s_mon;
    s_ot;
    test_done;
  end
endmodule
`default_nettype wire
